// ==== rtl/scse_pkg.sv ====
// Shared constants and types for the custom SPI sequence engine
package scse_pkg;

    // Clock period of the engine clock
    localparam int CLOCK_NS = 10;
    // One millisecond, in nanoseconds
    localparam int MS_NS = 1000000;
    // Cycles per millisecond, rounded down
    localparam int MS_CYCLES = MS_NS / CLOCK_NS;
    // Least half period of the serial clock
    localparam int SCK_HALF_NS = 50;
    // Half period in cycles, rounded up
    localparam int SCK_HALF_CYCLES = (SCK_HALF_NS + CLOCK_NS - 1) / CLOCK_NS;

    // Scratch buffer size in bytes
    localparam int BUF_BYTES = 16;
    // Most steps in one operation list
    localparam int LIST_DEPTH = 32;
    // Byte sent while reading into the scratch buffer
    localparam logic [7:0] READ_FILL = 8'hff;
    // Idle level of chip select (deasserted)
    localparam logic CS_IDLE = 1'b1;
    // Reset value of scratch bytes
    localparam logic [7:0] BUF_RESET = 8'h00;

    // List selector values
    localparam logic LIST_INIT = 1'b0;
    localparam logic LIST_EXIT = 1'b1;

    // Operation codes of one step
    typedef enum logic [3:0] {
        scse_op_delay,
        scse_op_cs_on,
        scse_op_cs_off,
        scse_op_write,
        scse_op_var_read,
        scse_op_var_write,
        scse_op_var_and,
        scse_op_var_or,
        scse_op_var_xor
    } scse_op_e;

    // One step of an operation list
    typedef struct packed {
        scse_op_e op;               // Operation
        logic [15:0] value0;        // Count, ms, offset or index
        logic [7:0] value1;         // Count or operand value
        logic [0:15][7:0] data;     // Literal bytes, data[0] sent first
    } scse_step_s;

    // Step load request
    typedef struct packed {
        logic list;                 // Target list
        logic [4:0] index;          // Step position
        scse_step_s step;           // Step contents
    } scse_load_s;

endpackage : scse_pkg

// ==== rtl/scse_spi_byte.sv ====
// One-byte SPI shifter, MSB first, serial clock made by a divider
`timescale 1ns/1ns
module scse_spi_byte
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Byte request
    input wire logic start,
    input wire logic [7:0] tx,
    output logic done,
    output logic [7:0] rx,
    // Serial lines, data in through a two-stage synchroniser
    input wire logic miso,
    output logic sck,
    output logic mosi
);
    import scse_pkg::*;

    logic active;           // Byte in progress
    logic [7:0] half_cnt;   // Cycles within half period
    logic [2:0] bit_cnt;    // Bits done
    logic [7:0] shreg;      // Outgoing bits
    logic [7:0] rxreg;      // Incoming bits
    logic miso_meta;        // Synchroniser first stage
    logic miso_sync;        // Synchronised data in

    // Data-in pin passes two flip-flops
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            miso_meta <= 1'b0;
            miso_sync <= 1'b0;
        end
        else
        begin
            miso_meta <= miso;
            miso_sync <= miso_meta;
        end
    end

    // Divider, shift on the falling and sample on the rising serial clock edge
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            active <= 1'b0;
            half_cnt <= 8'h00;
            bit_cnt <= 3'h0;
            shreg <= 8'h00;
            rxreg <= 8'h00;
            rx <= 8'h00;
            done <= 1'b0;
            sck <= 1'b0;
            mosi <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (!active)
            begin
                // Load byte, first bit set up before the rising edge
                if (start)
                begin
                    active <= 1'b1;
                    shreg <= tx;
                    mosi <= tx[7];
                    half_cnt <= 8'h00;
                    bit_cnt <= 3'h0;
                end
            end
            else if (half_cnt != 8'(SCK_HALF_CYCLES - 1))
            begin
                half_cnt <= half_cnt + 8'h01;
            end
            else
            begin
                half_cnt <= 8'h00;
                if (!sck)
                begin
                    // Rising edge: sample data in
                    sck <= 1'b1;
                    rxreg <= {rxreg[6:0], miso_sync};
                end
                else
                begin
                    // Falling edge: next bit or finish after eight
                    sck <= 1'b0;
                    if (bit_cnt == 3'h7)
                    begin
                        active <= 1'b0;
                        done <= 1'b1;
                        rx <= rxreg;
                    end
                    else
                    begin
                        bit_cnt <= bit_cnt + 3'h1;
                        shreg <= {shreg[6:0], 1'b0};
                        mosi <= shreg[6];
                    end
                end
            end
        end
    end

endmodule : scse_spi_byte

// ==== rtl/scse_engine.sv ====
// Custom SPI sequence engine: runs init and exit operation lists
`timescale 1ns/1ns
module scse_engine
#(
    parameter int MS_CYCLES_P = scse_pkg::MS_CYCLES
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // List loading
    input wire logic load_en,
    input wire scse_pkg::scse_load_s load,
    input wire logic [5:0] init_len,
    input wire logic [5:0] exit_len,
    // Run control
    input wire logic connect_req,
    input wire logic program_done,
    output logic busy,
    output logic init_done,
    output logic exit_done,
    // Scratch buffer readback
    input wire logic [3:0] buf_rd_index,
    output logic [7:0] buf_rd_data,
    // SPI pins
    output logic spi_cs_n,
    output logic spi_sck,
    output logic spi_mosi,
    input wire logic spi_miso
);
    import scse_pkg::*;

    typedef enum logic [2:0] {
        scse_idle,
        scse_fetch,
        scse_exec,
        scse_xfer,
        scse_wait,
        scse_delay
    } scse_state_e;

    scse_state_e state;                     // Sequencer state
    scse_step_s step_mem [0:2*LIST_DEPTH-1]; // Both operation lists
    scse_step_s cur;                        // Step being executed
    logic [7:0] scratch [0:BUF_BYTES-1];    // Scratch buffer
    logic run_list;                         // List being run
    logic [5:0] step_idx;                   // Current step position, one past the end allowed
    logic [5:0] run_len;                    // Steps in running list
    logic [4:0] byte_cnt;                   // Bytes done in this step
    logic [4:0] byte_num;                   // Bytes wanted in this step
    logic [3:0] scratch_offset;             // Scratch start offset
    logic [15:0] ms_left;                   // Milliseconds still to wait
    logic [31:0] tick_cnt;                  // Cycles within a millisecond
    logic byte_start;                       // Shifter request
    logic [7:0] byte_tx;                    // Shifter outgoing byte
    logic byte_done;                        // Shifter finished
    logic [7:0] byte_rx;                    // Shifter incoming byte

    // Scratch position for byte n of a buffered transfer, wraps at 16
    function automatic logic [3:0] buf_pos(input logic [3:0] off, input logic [4:0] n);
        buf_pos = off + n[3:0];
    endfunction : buf_pos

    // Clamp a requested count to the scratch size
    function automatic logic [4:0] clamp16(input logic [15:0] n);
        clamp16 = (n > 16'(BUF_BYTES)) ? 5'(BUF_BYTES) : n[4:0];
    endfunction : clamp16

    // List storage, written by the loader
    always_ff @(posedge clock)
    begin
        if (load_en)
        begin
            step_mem[{load.list, load.index}] <= load.step;
        end
    end

    // Sequencer
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state <= scse_idle;
            cur <= '0;
            run_list <= LIST_INIT;
            step_idx <= 6'h00;
            run_len <= 6'h00;
            byte_cnt <= 5'h00;
            byte_num <= 5'h00;
            scratch_offset <= 4'h0;
            ms_left <= 16'h0000;
            tick_cnt <= 32'h00000000;
            byte_start <= 1'b0;
            byte_tx <= 8'h00;
            spi_cs_n <= CS_IDLE;
            busy <= 1'b0;
            init_done <= 1'b0;
            exit_done <= 1'b0;
            for (int i = 0; i < BUF_BYTES; i++)
            begin
                scratch[i] <= BUF_RESET;
            end
        end
        else
        begin
            byte_start <= 1'b0;
            init_done <= 1'b0;
            exit_done <= 1'b0;
            case (state)
                scse_idle:
                begin
                    // Connect starts init; programming done starts exit
                    if (connect_req || program_done)
                    begin
                        run_list <= connect_req ? LIST_INIT : LIST_EXIT;
                        run_len <= connect_req ? init_len : exit_len;
                        step_idx <= 6'h00;
                        busy <= 1'b1;
                        state <= scse_fetch;
                    end
                end
                scse_fetch:
                begin
                    // Next step in list order, or end of list
                    // A length above the list depth stops after the last slot
                    if (step_idx >= run_len || step_idx == 6'(LIST_DEPTH))
                    begin
                        busy <= 1'b0;
                        init_done <= (run_list == LIST_INIT);
                        exit_done <= (run_list == LIST_EXIT);
                        state <= scse_idle;
                    end
                    else
                    begin
                        cur <= step_mem[{run_list, step_idx[4:0]}];
                        state <= scse_exec;
                    end
                end
                scse_exec:
                begin
                    byte_cnt <= 5'h00;
                    state <= scse_fetch;
                    step_idx <= step_idx + 6'h01;
                    case (cur.op)
                        scse_op_cs_on, scse_op_cs_off: // Low to select, high to release
                        begin
                            spi_cs_n <= (cur.op == scse_op_cs_off);
                        end
                        scse_op_write:
                        begin
                            byte_num <= clamp16(cur.value0);
                            if (cur.value0 != 16'h0000)
                            begin
                                step_idx <= step_idx;
                                state <= scse_xfer;
                            end
                        end
                        scse_op_var_read, scse_op_var_write:
                        begin
                            scratch_offset <= cur.value0[3:0];
                            byte_num <= clamp16({8'h00, cur.value1});
                            if (cur.value1 != 8'h00)
                            begin
                                step_idx <= step_idx;
                                state <= scse_xfer;
                            end
                        end
                        scse_op_var_and:
                        begin
                            scratch[cur.value0[3:0]] <= scratch[cur.value0[3:0]] & cur.value1;
                        end
                        scse_op_var_or:
                        begin
                            scratch[cur.value0[3:0]] <= scratch[cur.value0[3:0]] | cur.value1;
                        end
                        scse_op_var_xor:
                        begin
                            scratch[cur.value0[3:0]] <= scratch[cur.value0[3:0]] ^ cur.value1;
                        end
                        scse_op_delay:
                        begin
                            ms_left <= cur.value0;
                            tick_cnt <= 32'h00000000;
                            if (cur.value0 != 16'h0000)
                            begin
                                step_idx <= step_idx;
                                state <= scse_delay;
                            end
                        end
                        default:
                        begin
                            // Unknown code is skipped
                        end
                    endcase
                end
                scse_xfer:
                begin
                    // Pick the byte to send and start the shifter
                    byte_start <= 1'b1;
                    if (cur.op == scse_op_write)
                    begin
                        byte_tx <= cur.data[byte_cnt[3:0]];
                    end
                    else if (cur.op == scse_op_var_write)
                    begin
                        byte_tx <= scratch[buf_pos(scratch_offset, byte_cnt)];
                    end
                    else
                    begin
                        byte_tx <= READ_FILL;
                    end
                    state <= scse_wait;
                end
                scse_wait:
                begin
                    // Whole byte done before the next one or next step
                    if (byte_done)
                    begin
                        if (cur.op == scse_op_var_read)
                        begin
                            scratch[buf_pos(scratch_offset, byte_cnt)] <= byte_rx;
                        end
                        byte_cnt <= byte_cnt + 5'h01;
                        if (byte_cnt + 5'h01 == byte_num)
                        begin
                            step_idx <= step_idx + 6'h01;
                            state <= scse_fetch;
                        end
                        else
                        begin
                            state <= scse_xfer;
                        end
                    end
                end
                scse_delay:
                begin
                    // Count whole milliseconds
                    if (tick_cnt == 32'(MS_CYCLES_P - 1))
                    begin
                        tick_cnt <= 32'h00000000;
                        ms_left <= ms_left - 16'h0001;
                        if (ms_left == 16'h0001)
                        begin
                            step_idx <= step_idx + 6'h01;
                            state <= scse_fetch;
                        end
                    end
                    else
                    begin
                        tick_cnt <= tick_cnt + 32'h00000001;
                    end
                end
                default:
                begin
                    state <= scse_idle;
                end
            endcase
        end
    end

    // Scratch readback register, zero in reset as scratch is cleared
    always_ff @(posedge clock)
    begin
        buf_rd_data <= scratch[buf_rd_index];
    end

    // Byte shifter, drives the serial clock and data out
    scse_spi_byte u_byte
    (
        .clock(clock),
        .rst(rst),
        .start(byte_start),
        .tx(byte_tx),
        .done(byte_done),
        .rx(byte_rx),
        .miso(spi_miso),
        .sck(spi_sck),
        .mosi(spi_mosi)
    );

endmodule : scse_engine

// ==== verif/scse_engine_sva.sv ====
// Assertions on the sequence engine's run control and SPI pins
`timescale 1ns/1ns
module scse_engine_sva
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Run control
    input wire logic connect_req,
    input wire logic program_done,
    input wire logic busy,
    input wire logic init_done,
    input wire logic exit_done,
    // SPI pins
    input wire logic spi_cs_n,
    input wire logic spi_sck,
    input wire logic spi_mosi
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    // High phase of one serial bit
    sequence s_sck_high;
        spi_sck [*5] ##1 !spi_sck;
    endsequence

    // Shortest low phase of the serial clock
    sequence s_sck_low;
        !spi_sck [*5];
    endsequence

    // Idle and not finishing, so a request is taken
    logic idle;
    assign idle = !busy && !init_done && !exit_done;

    // Chip select moves only from a running step
    a_cs_moves_busy: assert property ($changed(spi_cs_n) |-> $past(busy))
        else $error("chip select changed outside a run");
    // Serial clock quiet when no list runs
    a_sck_only_busy: assert property (spi_sck |-> busy)
        else $error("serial clock high while idle");
    // Each bit high for exactly five cycles
    a_sck_high_len: assert property ($rose(spi_sck) |-> s_sck_high)
        else $error("serial clock high phase wrong");
    // Low phase never shorter than five cycles
    a_sck_low_len: assert property ($fell(spi_sck) |-> s_sck_low)
        else $error("serial clock low phase short");
    // Data out steady while the target samples
    a_mosi_held: assert property (spi_sck |-> $stable(spi_mosi))
        else $error("data out moved while clock high");
    // Chip select untouched across the high phase of a bit
    a_cs_held_bit: assert property ($rose(spi_sck) |-> $stable(spi_cs_n) throughout s_sck_high)
        else $error("chip select moved during a transfer");
    // Connect request starts the init list
    a_init_start: assert property (idle && connect_req |=> busy)
        else $error("connect request not taken");
    // Programming end starts the exit list
    a_exit_start: assert property (idle && program_done |=> busy)
        else $error("program done not taken");
    // Done ends a run on the same edge
    a_done_ends_run: assert property ((init_done || exit_done) |-> !busy && $past(busy))
        else $error("done without a run ending");
    // Done flags are single pulses
    a_done_pulse: assert property ((init_done || exit_done) |=> !init_done && !exit_done)
        else $error("done flag longer than a cycle");
endmodule : scse_engine_sva

bind scse_engine scse_engine_sva u_sva (.clock(clock), .rst(rst), .connect_req(connect_req),
    .program_done(program_done), .busy(busy), .init_done(init_done), .exit_done(exit_done),
    .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_mosi(spi_mosi));

// ==== verif/scse_flash_model.sv ====
// Serial flash stand-in: records bytes received, answers a counting pattern
`timescale 1ns/1ns
module scse_flash_model
(
    // SPI pins
    input wire logic spi_cs_n,
    input wire logic spi_sck,
    input wire logic spi_mosi,
    output logic spi_miso
);
    logic [7:0] shift = 8'h00; // Bits gathered this byte
    logic [7:0] resp = 8'h81; // Answer byte, 0x81 plus frame position
    int bit_cnt = 0; // Bits seen in current byte
    logic [7:0] got[$]; // Every byte received while selected

    initial spi_miso = 1'b0;

    // Frame start, first answer bit ready before the first rise
    always @(negedge spi_cs_n)
    begin
        bit_cnt = 0;
        resp = 8'h81;
        spi_miso = resp[7];
    end

    // Released line shows the inverse, not a held value
    always @(posedge spi_cs_n)
        spi_miso = ~spi_miso;

    // Sample on the rise, MSB first, eight bits a byte
    always @(posedge spi_sck)
    begin
        if (!spi_cs_n)
        begin
            shift = {shift[6:0], spi_mosi};
            bit_cnt++;
            if (bit_cnt == 8)
            begin
                got.push_back(shift);
                bit_cnt = 0;
                resp = resp + 8'h01;
            end
        end
    end

    // Next answer bit on the fall, as mode 0 targets do
    always @(negedge spi_sck)
    begin
        if (!spi_cs_n)
            spi_miso = resp[7 - bit_cnt];
    end
endmodule : scse_flash_model

// ==== verif/spi_custom_sequence_engine_tb.sv ====
// Self-checking bench for the custom SPI sequence engine
`timescale 1ns/1ns
module spi_custom_sequence_engine_tb;
    import scse_pkg::*;

    localparam int MSC = 20; // Short millisecond for simulation

    // Edit cases: operation, index, operand, byte expected after
    typedef struct {scse_op_e op; logic [3:0] idx; logic [7:0] val; logic [7:0] exp;} scse_row_s;
    scse_row_s rows[5] = '{'{scse_op_var_and, 4'h0, 8'h0f, 8'h05},
        '{scse_op_var_or, 4'h0, 8'h30, 8'h35}, '{scse_op_var_xor, 4'h1, 8'hff, 8'h79},
        '{scse_op_var_xor, 4'hf, 8'h84, 8'h00}, '{scse_op_var_or, 4'h2, 8'h12, 8'h12}};

    logic clock = 1'b0, rst = 1'b1, load_en = 1'b0; // Clock and controls
    logic connect_req = 1'b0, program_done = 1'b0; // Run requests
    scse_load_s load = '0; // Step being loaded
    logic [5:0] init_len = 6'h00, exit_len = 6'h00; // List lengths
    logic [3:0] buf_rd_index = 4'h0; // Readback index
    logic busy, init_done, exit_done, spi_cs_n, spi_sck, spi_mosi, spi_miso; // Design outputs and flash data out
    logic [7:0] buf_rd_data; // Readback data
    int err_total = 0; // Mismatches seen
    int comparisons = 0; // Compares made
    int inits = 0; // Init completions seen
    time cs_up = 0; // Last chip select release

    scse_engine #(.MS_CYCLES_P(MSC)) u_dut (.clock(clock), .rst(rst), .load_en(load_en),
        .load(load), .init_len(init_len), .exit_len(exit_len), .connect_req(connect_req),
        .program_done(program_done), .busy(busy), .init_done(init_done), .exit_done(exit_done),
        .buf_rd_index(buf_rd_index), .buf_rd_data(buf_rd_data), .spi_cs_n(spi_cs_n),
        .spi_sck(spi_sck), .spi_mosi(spi_mosi), .spi_miso(spi_miso));

    scse_flash_model u_flash (.spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_mosi(spi_mosi),
        .spi_miso(spi_miso));

    // Clock, 10 ns period
    initial
    begin
        forever #5 clock = ~clock;
    end

    // Count init completions, note chip select releases
    always @(posedge clock)
        if (init_done === 1'b1)
            inits++;
    always @(posedge spi_cs_n)
        cs_up = $time;

    // Verdict and end of run
    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done

    // Compare a byte
    task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp_byte

    // Compare a single bit
    task automatic cmp_bit(input string what, input logic exp, input logic got);
        cmp_byte(what, {7'h00, exp}, {7'h00, got});
    endtask : cmp_bit

    // Compare a count
    task automatic cmp_count(input string what, input int exp, input int got);
        comparisons++;
        if (got != exp)
        begin
            err_total++;
            $display("mismatch %s expected %0d seen %0d", what, exp, got);
        end
    endtask : cmp_count

    // Load one step into a list
    task automatic put_step(input logic lst, input logic [4:0] idx, input scse_op_e op,
        input logic [15:0] v0, input logic [7:0] v1, input logic [0:15][7:0] d);
        @(posedge clock);
        #1;
        load_en = 1'b1;
        load = '{lst, idx, '{op, v0, v1, d}};
        @(posedge clock);
        #1;
        load_en = 1'b0;
    endtask : put_step

    // Start a list, optionally poke a refused request, wait for done
    task automatic run(input logic lst, input logic [5:0] len, input bit poke);
        int n;
        n = 0;
        init_len = len;
        exit_len = len;
        u_flash.got.delete();
        connect_req = (lst == LIST_INIT);
        program_done = (lst == LIST_EXIT);
        @(posedge clock);
        #1;
        program_done = 1'b0;
        while ((init_done | exit_done) !== 1'b1 && n < 5000)
        begin
            connect_req = poke && n == 5;
            @(posedge clock);
            #1;
            n++;
        end
        cmp_bit("done flag", 1'b1, lst ? exit_done : init_done);
    endtask : run

    // Read one scratch byte back
    task automatic peek(input logic [3:0] idx, input logic [7:0] exp);
        buf_rd_index = idx;
        @(posedge clock);
        #1;
        cmp_byte("scratch byte", exp, buf_rd_data);
    endtask : peek

    // Bytes the flash received, in order
    task automatic check_sent(input logic [7:0] exp[$]);
        cmp_count("bytes sent", exp.size(), u_flash.got.size());
        foreach (exp[i])
            cmp_byte("byte sent", exp[i], u_flash.got[i]);
    endtask : check_sent

    // Watchdog, far beyond the expected run length
    initial
    begin
        #400000;
        err_total++;
        test_done();
    end

    // Main sequence
    initial
    begin
        repeat (16) @(posedge clock);
        #1;
        rst = 1'b0;
        cmp_bit("cs idle", 1'b1, spi_cs_n);
        cmp_bit("busy idle", 1'b0, busy);
        peek(4'h0, 8'h00);
        // Init: select, two literals, wrapped read of four, deselect
        put_step(LIST_INIT, 5'd0, scse_op_cs_on, 16'h0, 8'h0, '0);
        put_step(LIST_INIT, 5'd1, scse_op_write, 16'h2, 8'h0, {8'h9f, 8'h13, 112'h0});
        put_step(LIST_INIT, 5'd2, scse_op_var_read, 16'he, 8'h4, '0);
        put_step(LIST_INIT, 5'd3, scse_op_cs_off, 16'h0, 8'h0, '0);
        run(LIST_INIT, 6'd4, 1'b0);
        check_sent({8'h9f, 8'h13, 8'hff, 8'hff, 8'hff, 8'hff});
        cmp_bit("cs released", 1'b1, spi_cs_n);
        peek(4'he, 8'h83);
        peek(4'hf, 8'h84);
        peek(4'h0, 8'h85);
        peek(4'h1, 8'h86);
        // One-step exit lists editing scratch bytes
        foreach (rows[i])
        begin
            put_step(LIST_EXIT, 5'd0, rows[i].op, {12'h0, rows[i].idx}, rows[i].val, '0);
            run(LIST_EXIT, 6'd1, 1'b0);
            peek(rows[i].idx, rows[i].exp);
        end
        // Exit: buffered write across the wrap, then a delay; poke is refused
        put_step(LIST_EXIT, 5'd0, scse_op_cs_on, 16'h0, 8'h0, '0);
        put_step(LIST_EXIT, 5'd1, scse_op_var_write, 16'hf, 8'h3, '0);
        put_step(LIST_EXIT, 5'd2, scse_op_cs_off, 16'h0, 8'h0, '0);
        put_step(LIST_EXIT, 5'd3, scse_op_delay, 16'h2, 8'h0, '0);
        run(LIST_EXIT, 6'd4, 1'b1);
        check_sent({8'h00, 8'h35, 8'h79});
        cmp_bit("delay span", 1'b1, ($time - cs_up) / 10 inside {[2 * MSC:2 * MSC + 8]});
        // Reset in mid-transfer: run dropped, pins idle, scratch cleared
        connect_req = 1'b1;
        @(posedge clock);
        #1;
        connect_req = 1'b0;
        repeat (100) @(posedge clock);
        #1;
        cmp_bit("cs held in transfer", 1'b0, spi_cs_n);
        rst = 1'b1;
        repeat (2) @(posedge clock);
        #1;
        rst = 1'b0;
        cmp_bit("cs after reset", 1'b1, spi_cs_n);
        cmp_bit("busy after reset", 1'b0, busy);
        cmp_bit("sck after reset", 1'b0, spi_sck);
        peek(4'he, 8'h00);
        cmp_count("init runs", 1, inits);
        test_done();
    end
endmodule : spi_custom_sequence_engine_tb
